//--- common/adc_seq_consts.vh
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

// conversion clock divide ratios, by divider select code
`define DIV_SEL_4 3'h0
`define DIV_SEL_2 3'h1
`define DIV_SEL_1A 3'h2
`define DIV_SEL_1B 3'h3
`define DIV_SEL_12 3'h4
`define DIV_SEL_6 3'h5
`define DIV_SEL_3A 3'h6
`define DIV_SEL_3B 3'h7
`define DIV_RATIO_1 4'h1
`define DIV_RATIO_2 4'h2
`define DIV_RATIO_3 4'h3
`define DIV_RATIO_4 4'h4
`define DIV_RATIO_6 4'h6
`define DIV_RATIO_12 4'hc

// conversion length and SAR steps in conversion-clock cycles, and the first SAR trial code
`define CYC_PLAIN_8 6'h31
`define CYC_PLAIN_10 6'h3b
`define CYC_SH_8 6'h1c
`define CYC_SH_10 6'h21
`define SAR_STEPS_8 6'h08
`define SAR_STEPS_10 6'h0a
`define SAR_FIRST_TRIAL 10'h200

// operating modes
`define MODE_ONE_SHOT 3'h0
`define MODE_REPEAT 3'h1
`define MODE_SINGLE_SWEEP 3'h2
`define MODE_REP_SWEEP0 3'h3
`define MODE_REP_SWEEP1 3'h4
`define MODE_SIMUL_SWEEP 3'h5
`define MODE_DELAY_TRIG0 3'h6
`define MODE_DELAY_TRIG1 3'h7

`define NUM_CHANNELS 8

`endif

//--- hdl/adc_clock_divider.v
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.vh"

module adc_clock_divider (
  input wire clk_sys_i,
  input wire resetn_i,
  input wire [2:0] div_sel_i,
  output reg phi_tick_o
);

  reg [3:0] ratio;
  reg [3:0] cnt_q;

  // ****************************************
  // ratio select
  // ****************************************
  always @*
  begin
    case (div_sel_i)
      `DIV_SEL_4: ratio = `DIV_RATIO_4;
      `DIV_SEL_2: ratio = `DIV_RATIO_2;
      `DIV_SEL_1A, `DIV_SEL_1B: ratio = `DIV_RATIO_1;
      `DIV_SEL_12: ratio = `DIV_RATIO_12;
      `DIV_SEL_6: ratio = `DIV_RATIO_6;
      default: ratio = `DIV_RATIO_3;
    endcase
  end

  // ****************************************
  // counter
  // ****************************************
  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cnt_q <= 4'h0;
      phi_tick_o <= 1'b0;
    end
    else if (cnt_q >= ratio - 4'h1)
    begin
      cnt_q <= 4'h0;
      phi_tick_o <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 4'h1;
      phi_tick_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- hdl/adc_sequencer_control.v
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_consts.vh"

module adc_sequencer_control (
  input wire clk_sys_i,
  input wire resetn_i,
  input wire clock_div_sel_bit0_i,
  input wire clock_div_sel_bit1_i,
  input wire clock_div_sel_bit2_i,
  input wire res_10bit_i,
  input wire sample_hold_en_i,
  input wire reference_connect_i,
  input wire [2:0] mode_i,
  input wire [1:0] group_sel_i,
  input wire [2:0] channel_sel_i,
  input wire [1:0] sweep_len_i,
  input wire trigger_source_select_i,
  input wire start_set_i,
  input wire start_clr_i,
  input wire external_trigger_input_i,
  input wire timer0_trigger_enable_i,
  input wire timer1_trigger_enable_i,
  input wire timer_trigger_i,
  input wire comparator_i,
  input wire [2:0] result_rd_idx_i,
  output reg reference_ladder_on_o,
  output reg [4:0] analog_mux_sel_o,
  output reg [9:0] sar_trial_code_o,
  output reg sample_hold_o,
  output reg conversion_start_bit_o,
  output reg busy_o,
  output reg conv_done_irq_o,
  output reg [9:0] channel_result_reg_o
);

  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT_TRIG = 2'h1;
  localparam ST_CONVERT = 2'h2;

  wire phi_tick;
  reg [1:0] state_q;
  reg [5:0] cyc_q;
  reg [2:0] ch_q;
  reg [1:0] grp_q;
  reg ext_prev_q;
  reg [9:0] channel_result_reg [0:`NUM_CHANNELS-1];

  reg [5:0] total_cyc;
  reg [5:0] sar_steps;
  reg [5:0] sar_start;
  reg [5:0] step;
  reg [3:0] pos;
  reg [9:0] sar_dec;
  reg [9:0] stored;
  reg sweep_mode;
  reg repeat_mode;
  reg [2:0] sweep_last;
  reg trig_seen;
  reg sw_trig;
  integer i;

  // ****************************************
  // conversion clock
  // ****************************************
  adc_clock_divider u_div (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .div_sel_i({clock_div_sel_bit2_i, clock_div_sel_bit1_i, clock_div_sel_bit0_i}),
    .phi_tick_o(phi_tick)
  );

  // ****************************************
  // timing and mode decode
  // ****************************************
  always @*
  begin
    if (sample_hold_en_i)
      total_cyc = res_10bit_i ? `CYC_SH_10 : `CYC_SH_8;
    else
      total_cyc = res_10bit_i ? `CYC_PLAIN_10 : `CYC_PLAIN_8;
    sar_steps = res_10bit_i ? `SAR_STEPS_10 : `SAR_STEPS_8;
    sar_start = total_cyc - sar_steps;
    step = cyc_q - sar_start;
    pos = 4'h9 - step[3:0];
    sar_dec = comparator_i ? sar_trial_code_o : (sar_trial_code_o & ~(10'h001 << pos));
    stored = res_10bit_i ? sar_dec : {2'b00, sar_dec[9:2]};
    sweep_mode = (mode_i != `MODE_ONE_SHOT) && (mode_i != `MODE_REPEAT);
    repeat_mode = (mode_i == `MODE_REPEAT) || (mode_i == `MODE_REP_SWEEP0) ||
      (mode_i == `MODE_REP_SWEEP1);
    sweep_last = {sweep_len_i, 1'b1};
    sw_trig = !trigger_source_select_i && (mode_i != `MODE_DELAY_TRIG0) &&
      (mode_i != `MODE_DELAY_TRIG1);
    if (mode_i == `MODE_DELAY_TRIG0 || mode_i == `MODE_DELAY_TRIG1)
      trig_seen = timer_trigger_i && timer0_trigger_enable_i && timer1_trigger_enable_i;
    else if (trigger_source_select_i)
      trig_seen = ext_prev_q && !external_trigger_input_i;
    else
      trig_seen = 1'b1;
  end

  // ****************************************
  // sequencer
  // ****************************************
  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q <= ST_IDLE;
      cyc_q <= 6'h00;
      ch_q <= 3'h0;
      grp_q <= 2'h0;
      ext_prev_q <= 1'b1;
      reference_ladder_on_o <= 1'b0;
      analog_mux_sel_o <= 5'h00;
      sar_trial_code_o <= 10'h000;
      sample_hold_o <= 1'b0;
      conversion_start_bit_o <= 1'b0;
      busy_o <= 1'b0;
      conv_done_irq_o <= 1'b0;
      channel_result_reg_o <= 10'h000;
      for (i = 0; i < `NUM_CHANNELS; i = i + 1)
        channel_result_reg[i] <= 10'h000;
    end
    else
    begin
      ext_prev_q <= external_trigger_input_i;
      reference_ladder_on_o <= reference_connect_i;
      channel_result_reg_o <= channel_result_reg[result_rd_idx_i];
      conv_done_irq_o <= 1'b0;
      if (start_set_i)
        conversion_start_bit_o <= 1'b1;
      else if (start_clr_i)
        conversion_start_bit_o <= 1'b0;
      analog_mux_sel_o <= {grp_q, ch_q};
      busy_o <= (state_q == ST_CONVERT);
      case (state_q)
        ST_IDLE:
        begin
          sample_hold_o <= 1'b0;
          if (conversion_start_bit_o && !start_clr_i)
          begin
            grp_q <= group_sel_i;
            ch_q <= sweep_mode ? 3'h0 : channel_sel_i;
            state_q <= ST_WAIT_TRIG;
          end
        end
        ST_WAIT_TRIG:
        begin
          if (!conversion_start_bit_o)
            state_q <= ST_IDLE;
          else if (trig_seen)
          begin
            cyc_q <= 6'h00;
            sar_trial_code_o <= 10'h000;
            state_q <= ST_CONVERT;
          end
        end
        ST_CONVERT:
        begin
          if (!conversion_start_bit_o)
          begin
            state_q <= ST_IDLE;
            sample_hold_o <= 1'b0;
          end
          else if (phi_tick)
          begin
            cyc_q <= cyc_q + 6'h01;
            sample_hold_o <= (cyc_q + 6'h01 < sar_start);
            if (cyc_q + 6'h01 == sar_start)
              sar_trial_code_o <= `SAR_FIRST_TRIAL;
            else if (cyc_q >= sar_start && cyc_q != total_cyc - 6'h01)
              sar_trial_code_o <= sar_dec | (10'h001 << (pos - 4'h1));
            if (cyc_q == total_cyc - 6'h01)
            begin
              channel_result_reg[ch_q] <= stored;
              sar_trial_code_o <= sar_dec;
              cyc_q <= 6'h00;
              if (sweep_mode && ch_q != sweep_last)
                ch_q <= ch_q + 3'h1;
              else if (repeat_mode)
                ch_q <= sweep_mode ? 3'h0 : channel_sel_i;
              else
              begin
                conv_done_irq_o <= 1'b1;
                ch_q <= sweep_mode ? 3'h0 : channel_sel_i;
                if (sw_trig)
                begin
                  if (!start_set_i)
                    conversion_start_bit_o <= 1'b0;
                  state_q <= ST_IDLE;
                end
                else
                  state_q <= ST_WAIT_TRIG;
              end
            end
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- tb/adc_seq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module adc_seq_checker (
  input wire clk_sys_i,
  input wire resetn_i,
  input wire reference_connect_i,
  input wire [2:0] mode_i,
  input wire trigger_source_select_i,
  input wire start_set_i,
  input wire start_clr_i,
  input wire [2:0] result_rd_idx_i,
  input wire reference_ladder_on_o,
  input wire conversion_start_bit_o,
  input wire busy_o,
  input wire conv_done_irq_o,
  input wire [9:0] channel_result_reg_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  a_ladder_follow: assert property ($past(resetn_i) |-> reference_ladder_on_o == $past(reference_connect_i))
    else $error("ladder");
  a_irq_pulse: assert property (conv_done_irq_o |=> !conv_done_irq_o) else $error("irq width");
  a_irq_clear_start: assert property (conv_done_irq_o && mode_i == 3'h0 && !trigger_source_select_i
    |-> ##[0:1] !conversion_start_bit_o) else $error("start kept");
  a_start_set: assert property (start_set_i |=> conversion_start_bit_o) else $error("start set");
  a_clear_halts: assert property (start_clr_i && !start_set_i |-> ##[1:3] !busy_o) else $error("halt");
  a_result_hold: assert property ($past(mode_i) == 3'h0 && !$past(conv_done_irq_o)
    && $past(result_rd_idx_i) == $past(result_rd_idx_i, 2) |-> $stable(channel_result_reg_o)) else $error("result");
  a_irq_after_busy: assert property ($rose(conv_done_irq_o) |-> $past(busy_o)) else $error("irq idle");
  a_start_fall_idle: assert property ($fell(conversion_start_bit_o) |-> ##[0:2] !busy_o) else $error("busy");
  cover property (conv_done_irq_o);
  cover property ($rose(busy_o));
  cover property ($fell(conversion_start_bit_o));
  cover property (conv_done_irq_o && mode_i == 3'h2);
endmodule
bind adc_sequencer_control adc_seq_checker chk (.clk_sys_i, .resetn_i, .reference_connect_i, .mode_i,
  .trigger_source_select_i, .start_set_i, .start_clr_i, .result_rd_idx_i, .reference_ladder_on_o,
  .conversion_start_bit_o, .busy_o, .conv_done_irq_o, .channel_result_reg_o);
`default_nettype wire

//--- tb/adc_front.sv
`timescale 1ns/1ps
`default_nettype none
module adc_front (
  input wire [9:0] level_i,
  input wire [4:0] mux_i,
  input wire [9:0] trial_i,
  output logic cmp_o
);
  // each selected input sits at its own level
  assign cmp_o = level_i + {5'h00, mux_i} >= trial_i;
endmodule
`default_nettype wire

//--- tb/adc_sequencer_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_control_bench;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] div = 3'h2, mode = 3'h0, ch = 3'h0, idx = 3'h0;
  logic [1:0] grp = 2'h0;
  logic res = 1'b0, sh = 1'b0, vref = 1'b1, src = 1'b0, st = 1'b0, clr = 1'b0, ext = 1'b1, tt = 1'b0;
  logic [9:0] lvl = 10'h155, last = 10'h000;
  logic [1:0] ten = 2'h0;
  wire cmp, lad, shs, sbit, busy, irq;
  wire [4:0] mux;
  wire [9:0] trial, rd;
  int n_fail = 0, comparisons = 0, cyc = 0;
  adc_sequencer_control dut (.clk_sys_i(clk), .resetn_i(rstn), .clock_div_sel_bit0_i(div[0]),
    .clock_div_sel_bit1_i(div[1]), .clock_div_sel_bit2_i(div[2]), .res_10bit_i(res), .sample_hold_en_i(sh),
    .reference_connect_i(vref), .mode_i(mode), .group_sel_i(grp), .channel_sel_i(ch), .sweep_len_i(2'h3),
    .trigger_source_select_i(src), .start_set_i(st), .start_clr_i(clr), .external_trigger_input_i(ext),
    .timer0_trigger_enable_i(ten[0]), .timer1_trigger_enable_i(ten[1]), .timer_trigger_i(tt), .comparator_i(cmp),
    .result_rd_idx_i(idx), .reference_ladder_on_o(lad), .analog_mux_sel_o(mux), .sar_trial_code_o(trial),
    .sample_hold_o(shs), .conversion_start_bit_o(sbit), .busy_o(busy), .conv_done_irq_o(irq),
    .channel_result_reg_o(rd));
  adc_front fe (.level_i(lvl), .mux_i(mux), .trial_i(trial), .cmp_o(cmp));
  initial forever #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      n_fail++;
      tally_and_finish;
    end
  end
  task automatic chk(input string w, input logic [9:0] e, input logic [9:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // 0 raises the start set, 1 the start clear, 2 the timer trigger
  task automatic pulse(input int w);
    @(posedge clk)
    case (w)
      0: st <= 1'b1;
      1: clr <= 1'b1;
      default: tt <= 1'b1;
    endcase
    @(posedge clk)
    begin
      st <= 1'b0;
      clr <= 1'b0;
      tt <= 1'b0;
    end
  endtask
  task automatic wait_irq(output int n);
    n = 0;
    do
    begin
      tick(1);
      n++;
    end
    while (irq !== 1'b1 && n < 1000);
  endtask
  task automatic chk_range(input string w, input int n, lo, hi);
    comparisons++;
    if (n < lo || n > hi)
    begin
      n_fail++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", w, lo, hi, n);
    end
  endtask
  // one software-started one-shot conversion of nc ticks at ratio rt, timed and read back
  task automatic conv(input logic [2:0] d, input logic r, s, input logic [2:0] c, input int nc, rt);
    int n;
    logic [1:0] g;
    g = 2'(c % 3'h3);
    @(posedge clk) div <= d;
    res <= r;
    sh <= s;
    ch <= c;
    grp <= g;
    idx <= c;
    pulse(0);
    wait_irq(n);
    chk_range("cycles", n, (nc - 1) * rt + 3, nc * rt + 2);
    tick(2);
    last = lvl + {5'h00, g, c};
    chk("final_code", r ? last : {last[9:2], 2'h0}, trial);
    chk("mux", {5'h00, g, c}, {5'h00, mux});
    last = r ? last : {2'h0, last[9:2]};
    chk("result", last, rd);
    chk("start_bit", 1'b0, sbit);
  endtask
  task automatic t_width;
    int nt[4] = '{49, 28, 59, 33};
    for (int k = 0; k < 4; k++)
      conv(3'h0, k[1], k[0], 3'(k + 4), nt[k], 4);
    $display("width test done");
  endtask
  task automatic t_divider;
    int rt[8] = '{4, 2, 1, 1, 12, 6, 3, 3};
    for (int d = 0; d < 8; d++)
      conv(3'(d), 1'b0, 1'b1, 3'(d), 28, rt[d]);
    $display("divider test done");
  endtask
  task automatic t_ext;
    int n;
    @(posedge clk) src <= 1'b1;
    div <= 3'h0;
    pulse(0);
    tick(20);
    chk("busy_before_edge", 1'b0, busy);
    @(posedge clk) ext <= 1'b0;
    wait_irq(n);
    chk("irq_after_edge", 1'b1, irq);
    pulse(1);
    @(posedge clk) src <= 1'b0;
    ext <= 1'b1;
    $display("trigger test done");
  endtask
  task automatic t_abort;
    int n;
    @(posedge clk) lvl <= 10'h0aa;
    div <= 3'h0;
    pulse(0);
    tick(15);
    chk("sample_hold", 1'b1, shs);
    pulse(1);
    wait_irq(n);
    chk("irq_after_clear", 1'b0, irq);
    chk("busy_after_clear", 1'b0, busy);
    chk("result_kept", last, rd);
    @(posedge clk) lvl <= 10'h155;
    $display("abort test done");
  endtask
  task automatic t_sweep;
    int n;
    logic [9:0] x;
    @(posedge clk) mode <= 3'h2;
    vref <= 1'b1;
    div <= 3'h0;
    res <= 1'b0;
    sh <= 1'b1;
    grp <= 2'h2;
    pulse(0);
    wait_irq(n);
    chk_range("sweep_cycles", n, (8 * 28 - 1) * 4 + 3, 8 * 28 * 4 + 2);
    chk("sweep_start_bit", 1'b0, sbit);
    for (int k = 0; k < 8; k++)
    begin
      @(posedge clk) idx <= 3'(k);
      tick(2);
      x = lvl + {5'h00, 2'h2, 3'(k)};
      chk("sweep_result", {2'h0, x[9:2]}, rd);
    end
    $display("sweep test done");
  endtask
  task automatic t_modes;
    @(posedge clk) ten <= 2'h3;
    for (int m = 0; m < 8; m++)
    begin
      @(posedge clk) mode <= 3'(m);
      pulse(0);
      pulse(2);
      tick(3);
      chk("busy_in_mode", 1'b1, busy);
      pulse(1);
      tick(4);
      chk("busy_halted", 1'b0, busy);
    end
    @(posedge clk) vref <= 1'b0;
    tick(2);
    chk("ladder", 1'b0, lad);
    $display("mode test done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_width;
    t_divider;
    t_ext;
    t_abort;
    t_modes;
    t_sweep;
    tally_and_finish;
  end
endmodule
`default_nettype wire
